/* design/pis_pkg.sv */
package pis_pkg;
   // ****************************************************
   // Modes and constants
   // ****************************************************
   localparam logic TRIG_LEVEL = 1'b0;
   localparam logic TRIG_EDGE = 1'b1;
   localparam logic GRAN_BLOCK = 1'b0;
   localparam logic GRAN_OPER = 1'b1;
   localparam logic RST_PEND = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam int LINE_W_DEF = 4;

   typedef enum logic [1:0]
   {
      PIS_ST_IDLE = 2'b00,
      PIS_ST_HANDLER = 2'b01,
      PIS_ST_RESUME = 2'b10,
      PIS_ST_TIMED = 2'b11
   } pis_state_type;

   // Sequencer boundary and instruction events, one-cycle pulses; in_function_block is a held level
   typedef struct packed
   {
      logic block_boundary;
      logic oper_boundary;
      logic block_end_instruction;
      logic disable_interrupts_instruction;
      logic enable_interrupts_instruction;
      logic in_function_block;
   } pis_seq_ev_type;

   // Configuration from extended_config_block
   typedef struct packed
   {
      logic trigger_edge;
      logic oper_granularity;
      logic handler_loaded;
   } pis_cfg_type;
endpackage

/* design/pis_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module pis_sequencer
   import pis_pkg::*;
#(
   parameter int LINE_W = LINE_W_DEF
)
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [LINE_W-1:0] irq_lines_i,
   input wire logic [$clog2(LINE_W)-1:0] slot_sel_i,
   input wire pis_pkg::pis_cfg_type cfg_i,
   input wire pis_pkg::pis_seq_ev_type ev_i,
   input wire logic interrupt_disable_service_i,
   input wire logic interrupt_defer_service_i,
   input wire logic time_req_i,
   input wire logic time_done_i,
   output logic call_handler_o,
   output logic call_time_o,
   output logic handler_active_o,
   output logic request_pending_o,
   output logic ints_disabled_o,
   output logic time_pending_o
);
   import pis_pkg::*;

   // ****************************************************
   // Line synchroniser and slot select
   // ****************************************************
   logic [LINE_W-1:0] sync1_q;
   logic [LINE_W-1:0] sync2_q;
   logic line_q;
   logic line_prev_q;
   logic rise;

   always_ff @(posedge clk_i)
   begin
      sync1_q <= irq_lines_i;
      sync2_q <= sync1_q;
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         line_q <= 1'b0;
         line_prev_q <= 1'b0;
      end
      else
      begin
         line_q <= sync2_q[slot_sel_i];
         line_prev_q <= line_q;
      end
   end

   assign rise = line_q & ~line_prev_q;

   // ****************************************************
   // Insertion point
   // ****************************************************
   function automatic logic is_point(input pis_seq_ev_type e,
                                     input logic oper);
      is_point = e.block_boundary | (oper & e.oper_boundary);
   endfunction

   pis_state_type state_q;
   logic pend_q;
   logic dis_q;
   logic timed_pend_q;
   logic point;
   logic blocked;
   logic take;
   logic take_time;
   logic handler_end;
   logic armed_q;
   logic rst_hold_q;

   assign point = is_point(ev_i, cfg_i.oper_granularity);
   assign blocked = dis_q | interrupt_disable_service_i
                  | interrupt_defer_service_i;
   assign handler_end = (state_q == PIS_ST_HANDLER)
                      & ev_i.block_end_instruction;
   assign take = pend_q & point & ~blocked & cfg_i.handler_loaded
               & ((state_q == PIS_ST_IDLE) | (state_q == PIS_ST_TIMED));
   assign take_time = timed_pend_q & point & ~take
                    & (state_q == PIS_ST_IDLE);

   // ****************************************************
   // Disable/enable instructions
   // ****************************************************
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         dis_q <= RST_FLAG;
      else if (ev_i.in_function_block)
      begin
         if (ev_i.disable_interrupts_instruction)
            dis_q <= 1'b1;
         else if (ev_i.enable_interrupts_instruction)
            dis_q <= 1'b0;
      end
   end

   // ****************************************************
   // Request latch
   // ****************************************************
   // Armed: level line still active at handler end
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         armed_q <= RST_FLAG;
      else if (handler_end)
         armed_q <= (cfg_i.trigger_edge == TRIG_LEVEL) & line_q;
      else if (state_q != PIS_ST_HANDLER)
         armed_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         pend_q <= RST_PEND;
      else if (!cfg_i.handler_loaded)
         pend_q <= 1'b0;
      else if (state_q == PIS_ST_HANDLER)
         pend_q <= 1'b0;
      else if (take)
         pend_q <= 1'b0;
      else if (armed_q)
         pend_q <= 1'b1;
      else if (cfg_i.trigger_edge == TRIG_EDGE)
      begin
         if (rise)
            pend_q <= 1'b1;
      end
      else if (rise | (line_q & (state_q == PIS_ST_IDLE) & ~rst_hold_q))
         pend_q <= 1'b1;
   end

   // After handler with line inactive, level needs a fresh rise
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         rst_hold_q <= RST_FLAG;
      else if (handler_end)
         rst_hold_q <= 1'b1;
      else if (!line_q)
         rst_hold_q <= 1'b0;
   end

   // ****************************************************
   // Execution level sequencing
   // ****************************************************
   logic timed_ret_q;

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_q <= PIS_ST_IDLE;
         timed_ret_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            PIS_ST_IDLE:
            begin
               if (take)
               begin
                  state_q <= PIS_ST_HANDLER;
                  timed_ret_q <= 1'b0;
               end
               else if (take_time)
                  state_q <= PIS_ST_TIMED;
            end
            PIS_ST_TIMED:
            begin
               if (take)
               begin
                  state_q <= PIS_ST_HANDLER;
                  timed_ret_q <= 1'b1;
               end
               else if (time_done_i)
                  state_q <= PIS_ST_IDLE;
            end
            PIS_ST_HANDLER:
               if (ev_i.block_end_instruction)
                  state_q <= PIS_ST_RESUME;
            PIS_ST_RESUME:
               if (point)
                  state_q <= timed_ret_q ? PIS_ST_TIMED
                                         : PIS_ST_IDLE;
            default:
               state_q <= PIS_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         timed_pend_q <= RST_PEND;
      else if (time_req_i)
         timed_pend_q <= 1'b1;
      else if (take_time)
         timed_pend_q <= 1'b0;
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         call_handler_o <= 1'b0;
         call_time_o <= 1'b0;
      end
      else
      begin
         call_handler_o <= take;
         call_time_o <= take_time;
      end
   end

   assign handler_active_o = (state_q == PIS_ST_HANDLER);
   assign request_pending_o = pend_q;
   assign ints_disabled_o = dis_q;
   assign time_pending_o = timed_pend_q;

   // ****************************************************
   // Assertions
   // ****************************************************
   property p_no_take_in_handler;
      @(posedge clk_i) disable iff (srst_i)
      (state_q == PIS_ST_HANDLER) |-> !take;
   endproperty
   a_no_take_in_handler: assert property (p_no_take_in_handler)
      else $error("handler re-entered");

   property p_take_on_point;
      @(posedge clk_i) disable iff (srst_i)
      take |-> point;
   endproperty
   a_take_on_point: assert property (p_take_on_point)
      else $error("handler inserted off boundary");

   property p_call_follows_take;
      @(posedge clk_i) disable iff (srst_i)
      take |=> call_handler_o && state_q == PIS_ST_HANDLER;
   endproperty
   a_call_follows_take: assert property (p_call_follows_take)
      else $error("handler call missing");

   property p_disabled_blocks;
      @(posedge clk_i) disable iff (srst_i)
      dis_q |-> !take;
   endproperty
   a_disabled_blocks: assert property (p_disabled_blocks)
      else $error("call while disabled");

   property p_no_handler;
      @(posedge clk_i) disable iff (srst_i)
      !cfg_i.handler_loaded |-> !take;
   endproperty
   a_no_handler: assert property (p_no_handler)
      else $error("call without handler");

   property p_process_first;
      @(posedge clk_i) disable iff (srst_i)
      take |-> !take_time;
   endproperty
   a_process_first: assert property (p_process_first)
      else $error("time taken over process");

   property p_time_waits;
      @(posedge clk_i) disable iff (srst_i)
      (state_q != PIS_ST_IDLE) |-> !take_time;
   endproperty
   a_time_waits: assert property (p_time_waits)
      else $error("time started during handler");

   property p_resume_first;
      @(posedge clk_i) disable iff (srst_i)
      $rose(state_q == PIS_ST_RESUME) |-> !take;
   endproperty
   a_resume_first: assert property (p_resume_first)
      else $error("no resume boundary");

   property p_clear_on_entry;
      @(posedge clk_i) disable iff (srst_i)
      take |=> !pend_q;
   endproperty
   a_clear_on_entry: assert property (p_clear_on_entry)
      else $error("latch not cleared");

   c_take: cover property (@(posedge clk_i) take);
   c_preempt: cover property (@(posedge clk_i)
      state_q == PIS_ST_TIMED && take);
   c_time: cover property (@(posedge clk_i) take_time);
endmodule
`default_nettype wire

/* test/pis_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pis_line_model
#(
   parameter int LINE_W = 4,
   parameter int SLOT = 0
)
(
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic noise_i,
   output logic [LINE_W-1:0] irq_lines_o
);
   // ****************************************************
   // Own slot line, other slots carry foreign traffic
   // ****************************************************
   always_ff @(posedge clk_i)
   begin
      for (int i = 0; i < LINE_W; i++)
      begin
         irq_lines_o[i] <= (i == SLOT) ? req_i : noise_i;
      end
   end
endmodule
`default_nettype wire

/* test/pis_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pis_sequencer_tb;
   import pis_pkg::*;
   localparam logic [5:0] BB = 6'b10_0000;
   localparam logic [5:0] OB = 6'b01_0000;
   localparam logic [5:0] EV_END = 6'b00_1000;
   localparam logic [5:0] DI = 6'b00_0100;
   localparam logic [5:0] EN = 6'b00_0010;
   logic clk, srst, req, noise, dsvc, fsvc, treq, tdone;
   logic call_h, call_t, act, pend, dis, tp, hc, tc, got;
   logic [3:0] lines;
   pis_cfg_type cfg;
   pis_seq_ev_type ev;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   pis_line_model #(.LINE_W(4), .SLOT(1)) pis_line_model_inst (
      .clk_i(clk), .req_i(req), .noise_i(noise), .irq_lines_o(lines));
   pis_sequencer #(.LINE_W(4)) pis_sequencer_inst (
      .clk_i(clk), .srst_i(srst), .irq_lines_i(lines),
      .slot_sel_i(2'd1), .cfg_i(cfg), .ev_i(ev),
      .interrupt_disable_service_i(dsvc),
      .interrupt_defer_service_i(fsvc), .time_req_i(treq),
      .time_done_i(tdone), .call_handler_o(call_h),
      .call_time_o(call_t), .handler_active_o(act),
      .request_pending_o(pend), .ints_disabled_o(dis),
      .time_pending_o(tp));
   // ****************************************************
   // Clock, timeout and tasks
   // ****************************************************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   task wrap_up();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic g, input logic e, input string m);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // Event pulse, collects call pulses over two cycles
   task pulse(input logic [5:0] m);
      ev = pis_seq_ev_type'(ev | m);
      @(posedge clk);
      #1;
      ev = pis_seq_ev_type'(ev & ~m);
      hc = call_h;
      tc = call_t;
      @(posedge clk);
      #1;
      hc = hc | call_h;
      tc = tc | call_t;
   endtask
   task line(input logic v);
      req = v;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task done_h();
      pulse(EV_END);
      pulse(BB);
   endtask
   // ****************************************************
   // Test sequence
   // ****************************************************
   initial
   begin
      {srst, req, noise, dsvc, fsvc, treq, tdone} = 7'b100_0000;
      cfg = '{trigger_edge: 1'b0, oper_granularity: 1'b0,
         handler_loaded: 1'b1};
      ev = '0;
      repeat (8) @(posedge clk);
      #1 srst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(act | pend | dis | tp | call_h | call_t, 1'b0, "reset status");
      line(1);
      chk(pend, 1'b1, "level sets pending");
      line(0);
      pulse(BB);
      chk(hc, 1'b1, "call with passive line");
      chk(pend, 1'b0, "latch cleared on entry");
      line(1);
      line(0);
      pulse(BB);
      chk(hc, 1'b0, "pulse in handler");
      done_h();
      pulse(BB);
      chk(hc, 1'b0, "no recall on idle line");
      chk(act, 1'b0, "handler ended");
      line(1);
      pulse(OB);
      chk(hc, 1'b0, "oper boundary in block mode");
      pulse(BB);
      pulse(EV_END);
      line(1);
      pulse(BB);
      chk(hc, 1'b0, "resume boundary");
      cfg.oper_granularity = 1'b1;
      pulse(OB);
      chk(hc, 1'b1, "level recall at oper boundary");
      line(0);
      done_h();
      cfg.oper_granularity = 1'b0;
      pulse(DI);
      chk(dis, 1'b0, "disable outside function block");
      for (int k = 0; k < 3; k++)
      begin
         ev.in_function_block = (k == 0);
         dsvc = (k == 1);
         fsvc = (k == 2);
         line(1);
         if (k == 0)
            pulse(DI);
         pulse(BB);
         chk(hc, 1'b0, "inhibited");
         if (k == 0)
            pulse(EN);
         {dsvc, fsvc} = 2'b00;
         pulse(BB);
         chk(hc, 1'b1, "released");
         line(0);
         done_h();
      end
      noise = 1'b1;
      line(0);
      chk(pend, 1'b0, "foreign slot line");
      noise = 1'b0;
      req = 1'b1;
      treq = 1'b1;
      @(posedge clk);
      #1 treq = 1'b0;
      line(1);
      pulse(BB);
      chk(hc & ~tc, 1'b1, "process before time");
      chk(tp, 1'b1, "time kept pending");
      line(0);
      done_h();
      got = 1'b0;
      repeat (3)
      begin
         pulse(BB);
         got = got | tc;
      end
      chk(got, 1'b1, "time after handler");
      line(1);
      pulse(BB);
      chk(hc, 1'b1, "preempt time program");
      line(0);
      done_h();
      tdone = 1'b1;
      @(posedge clk);
      #1 tdone = 1'b0;
      cfg.trigger_edge = 1'b1;
      line(1);
      pulse(BB);
      pulse(EV_END);
      line(1);
      pulse(BB);
      pulse(BB);
      chk(hc, 1'b0, "edge mode held line");
      line(0);
      line(1);
      pulse(BB);
      chk(hc, 1'b1, "edge mode new rise");
      line(0);
      done_h();
      cfg.handler_loaded = 1'b0;
      line(1);
      pulse(BB);
      chk(hc, 1'b0, "no handler loaded");
      wrap_up();
   end
endmodule
`default_nettype wire
